//--- scif_event_flags.sv
// clock and power event flags: live status mirror, rising-edge flags, enables, one irq line.
// assumes status sources are asynchronous to clock; each passes two flops before use.
module scif_event_flags
	import scif_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        pll_lock_timeout,
	input  wire logic        pll_lock_fall,
	input  wire logic        pll_lock_rise,
	input  wire logic        brownout_sync_ready,
	input  wire logic        brownout_detected,
	input  wire logic        brownout_ready,
	input  wire logic        fll_ref_clock_stopped,
	input  wire logic        fll_coarse_lock,
	input  wire logic        fll_fine_lock,
	input  wire logic        fll_out_of_bounds,
	input  wire logic        fll_ready,
	input  wire logic        rc8m_ready,
	input  wire logic        rc32k_ready,
	input  wire logic        crystal32k_ready,
	input  wire logic        crystal_ready,
	output logic             irq
);
	import scif_pkg::*;

	// whole module state in one record
	typedef struct packed {
		logic [31:0] sync1;   // first synchroniser stage, read only by sync2
		logic [31:0] sync2;   // second stage: the live status seen by software
		logic [31:0] prev;    // sync2 one cycle late; edges are judged from sync2 only
		logic [31:0] flags;   // sticky event flags
		logic [31:0] enables; // interrupt enables
		logic [31:0] rdata;   // read data, valid the cycle after the strobe
	} scif_state_s;

	scif_state_s state;      // registered state
	scif_state_s next_state; // computed next state
	logic [31:0] raw_status; // sources packed into register layout
	logic [31:0] rise;       // zero-to-one changes of the live status
	logic [31:0] clear_mask; // write-one-to-clear pattern this cycle

	// mask a word to implemented bits so spare positions never hold state
	function automatic logic [31:0] implemented(input logic [31:0] value);
		return value & EVENT_MASK;
	endfunction

	// pack sources into the shared flag/status bit layout
	always_comb begin
		raw_status = READ_ZERO;
		raw_status[BIT_PLL_LOCK_TIMEOUT]  = pll_lock_timeout;
		raw_status[BIT_PLL_LOCK_FALL]     = pll_lock_fall;
		raw_status[BIT_PLL_LOCK_RISE]     = pll_lock_rise;
		raw_status[BIT_BROWNOUT_SYNC_RDY] = brownout_sync_ready;
		raw_status[BIT_BROWNOUT_DETECTED] = brownout_detected;
		raw_status[BIT_BROWNOUT_READY]    = brownout_ready;
		raw_status[BIT_FLL_REF_STOPPED]   = fll_ref_clock_stopped;
		raw_status[BIT_FLL_COARSE_LOCK]   = fll_coarse_lock;
		raw_status[BIT_FLL_FINE_LOCK]     = fll_fine_lock;
		raw_status[BIT_FLL_OUT_OF_BOUNDS] = fll_out_of_bounds;
		raw_status[BIT_FLL_READY]         = fll_ready;
		raw_status[BIT_RC8M_READY]        = rc8m_ready;
		raw_status[BIT_RC32K_READY]       = rc32k_ready;
		raw_status[BIT_CRYSTAL32K_READY]  = crystal32k_ready;
		raw_status[BIT_CRYSTAL_READY]     = crystal_ready;
	end

	// next-state logic for synchroniser, flags, enables and read port
	always_comb begin
		next_state = state;
		// two-flop synchroniser; edges are judged on the second stage only
		next_state.sync1 = implemented(raw_status);
		next_state.sync2 = state.sync1;
		next_state.prev  = state.sync2;
		// edge detect on the second stage: reading sync1 here could see a metastable level
		rise = implemented(state.sync2 & ~state.prev);
		// write one clears a flag, zeros are ignored
		clear_mask = (reg_write && reg_addr == OFF_FLAGS) ? implemented(reg_wdata) : READ_ZERO;
		// a rise in the clear cycle wins so no event is lost
		next_state.flags = (state.flags & ~clear_mask) | rise;
		// enable set/clear: zeros have no effect in either register
		if (reg_write && reg_addr == OFF_ENABLE_SET) begin
			next_state.enables = state.enables | implemented(reg_wdata);
		end else if (reg_write && reg_addr == OFF_ENABLE_CLR) begin
			next_state.enables = state.enables & ~implemented(reg_wdata);
		end
		// read data: unmapped addresses answer zero
		next_state.rdata = READ_ZERO;
		if (reg_read) begin
			case (reg_addr)
				OFF_ENABLE_CLR: next_state.rdata = state.enables;
				OFF_ENABLE_SET: next_state.rdata = state.enables;
				OFF_FLAGS:      next_state.rdata = state.flags;
				OFF_STATUS:     next_state.rdata = state.sync2;
				default:        next_state.rdata = READ_ZERO;
			endcase
		end
	end

	// state register with synchronous reset to documented values
	always_ff @(posedge clock) begin
		if (reset) begin
			state.sync1   <= RESET_STAT;
			state.sync2   <= RESET_STAT;
			state.prev    <= RESET_STAT;
			state.flags   <= RESET_FLAGS;
			state.enables <= RESET_EN;
			state.rdata   <= READ_ZERO;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rdata;
	// single level request; drops only when every enabled flag is clear
	assign irq = |(state.flags & state.enables);

	// checks
	chk_rise_sets_flag: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_PLL_LOCK_TIMEOUT] && !state.prev[BIT_PLL_LOCK_TIMEOUT])
		|=> state.flags[BIT_PLL_LOCK_TIMEOUT])
		else $error("lock timeout rise did not set flag");
	chk_set_over_clear: assert property (@(posedge clock) disable iff (reset)
		(reg_write && reg_addr == OFF_FLAGS && reg_wdata[BIT_CRYSTAL_READY]
		&& state.sync2[BIT_CRYSTAL_READY] && !state.prev[BIT_CRYSTAL_READY])
		|=> state.flags[BIT_CRYSTAL_READY])
		else $error("clear beat a simultaneous rise");
	chk_w1c_clears: assert property (@(posedge clock) disable iff (reset)
		(reg_write && reg_addr == OFF_FLAGS && reg_wdata[BIT_FLL_READY]
		&& !(state.sync2[BIT_FLL_READY] && !state.prev[BIT_FLL_READY]))
		|=> !state.flags[BIT_FLL_READY])
		else $error("write one did not clear flag");
	chk_zero_keeps: assert property (@(posedge clock) disable iff (reset)
		(reg_write && reg_addr == OFF_FLAGS && !reg_wdata[BIT_RC8M_READY] && state.flags[BIT_RC8M_READY])
		|=> state.flags[BIT_RC8M_READY])
		else $error("write zero changed flag");
	chk_enable_set: assert property (@(posedge clock) disable iff (reset)
		(reg_write && reg_addr == OFF_ENABLE_SET && reg_wdata[BIT_CRYSTAL_READY])
		|=> state.enables[BIT_CRYSTAL_READY])
		else $error("enable set did not take");
	chk_enable_hold: assert property (@(posedge clock) disable iff (reset)
		(state.enables[BIT_CRYSTAL_READY] && !(reg_write && reg_addr == OFF_ENABLE_CLR))
		|=> state.enables[BIT_CRYSTAL_READY])
		else $error("enable dropped without a clear");
	chk_irq_crystal: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_CRYSTAL_READY] && state.enables[BIT_CRYSTAL_READY]) |-> irq)
		else $error("enabled crystal flag gave no irq");
	chk_irq_quiet: assert property (@(posedge clock) disable iff (reset)
		((state.flags & state.enables) == READ_ZERO) |-> !irq)
		else $error("irq with no enabled flag");
	chk_spare_zero: assert property (@(posedge clock) disable iff (reset)
		((state.flags & ~EVENT_MASK) == READ_ZERO) && ((state.sync2 & ~EVENT_MASK) == READ_ZERO))
		else $error("spare bit holds a one");
	chk_status_read: assert property (@(posedge clock) disable iff (reset)
		(reg_read && reg_addr == OFF_STATUS) |=> reg_rdata == $past(state.sync2))
		else $error("status read mismatch");
	chk_flag_read: assert property (@(posedge clock) disable iff (reset)
		(reg_read && reg_addr == OFF_FLAGS) |=> reg_rdata == $past(state.flags))
		else $error("flag read mismatch");
	chk_status_delay: assert property (@(posedge clock) disable iff (reset)
		$rose(fll_ready) ##0 fll_ready [*3] |-> state.sync2[BIT_FLL_READY])
		else $error("status not mirrored after two flops");

	// each synchronised rise must leave its flag set one edge later

	chk_rise_lock_fall: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_PLL_LOCK_FALL] && !state.prev[BIT_PLL_LOCK_FALL]) |=> state.flags[BIT_PLL_LOCK_FALL])
		else $error("lock fall rise did not set flag");

	chk_rise_lock_rise: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_PLL_LOCK_RISE] && !state.prev[BIT_PLL_LOCK_RISE]) |=> state.flags[BIT_PLL_LOCK_RISE])
		else $error("lock rise rise did not set flag");

	chk_rise_bo_sync: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_BROWNOUT_SYNC_RDY] && !state.prev[BIT_BROWNOUT_SYNC_RDY]) |=> state.flags[BIT_BROWNOUT_SYNC_RDY])
		else $error("brownout sync rise did not set flag");

	chk_rise_bo_det: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_BROWNOUT_DETECTED] && !state.prev[BIT_BROWNOUT_DETECTED]) |=> state.flags[BIT_BROWNOUT_DETECTED])
		else $error("brownout detect rise did not set flag");

	chk_rise_bo_ready: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_BROWNOUT_READY] && !state.prev[BIT_BROWNOUT_READY]) |=> state.flags[BIT_BROWNOUT_READY])
		else $error("brownout ready rise did not set flag");

	chk_rise_ref_stop: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_FLL_REF_STOPPED] && !state.prev[BIT_FLL_REF_STOPPED]) |=> state.flags[BIT_FLL_REF_STOPPED])
		else $error("reference stop rise did not set flag");

	chk_rise_coarse: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_FLL_COARSE_LOCK] && !state.prev[BIT_FLL_COARSE_LOCK]) |=> state.flags[BIT_FLL_COARSE_LOCK])
		else $error("coarse lock rise did not set flag");

	chk_rise_fine: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_FLL_FINE_LOCK] && !state.prev[BIT_FLL_FINE_LOCK]) |=> state.flags[BIT_FLL_FINE_LOCK])
		else $error("fine lock rise did not set flag");

	chk_rise_oob: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_FLL_OUT_OF_BOUNDS] && !state.prev[BIT_FLL_OUT_OF_BOUNDS]) |=> state.flags[BIT_FLL_OUT_OF_BOUNDS])
		else $error("out of bounds rise did not set flag");

	chk_rise_fll_rdy: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_FLL_READY] && !state.prev[BIT_FLL_READY]) |=> state.flags[BIT_FLL_READY])
		else $error("fll ready rise did not set flag");

	chk_rise_rc8m: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_RC8M_READY] && !state.prev[BIT_RC8M_READY]) |=> state.flags[BIT_RC8M_READY])
		else $error("8 MHz ready rise did not set flag");

	chk_rise_rc32k: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_RC32K_READY] && !state.prev[BIT_RC32K_READY]) |=> state.flags[BIT_RC32K_READY])
		else $error("32 kHz ready rise did not set flag");

	chk_rise_xtal32k: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_CRYSTAL32K_READY] && !state.prev[BIT_CRYSTAL32K_READY]) |=> state.flags[BIT_CRYSTAL32K_READY])
		else $error("32 kHz crystal rise did not set flag");

	chk_rise_crystal: assert property (@(posedge clock) disable iff (reset)
		(state.sync2[BIT_CRYSTAL_READY] && !state.prev[BIT_CRYSTAL_READY]) |=> state.flags[BIT_CRYSTAL_READY])
		else $error("crystal ready rise did not set flag");

	// every enabled set flag must show on the single request line

	chk_irq_timeout: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_PLL_LOCK_TIMEOUT] && state.enables[BIT_PLL_LOCK_TIMEOUT]) |-> irq)
		else $error("enabled lock timeout flag gave no irq");

	chk_irq_lock_fall: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_PLL_LOCK_FALL] && state.enables[BIT_PLL_LOCK_FALL]) |-> irq)
		else $error("enabled lock fall flag gave no irq");

	chk_irq_lock_rise: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_PLL_LOCK_RISE] && state.enables[BIT_PLL_LOCK_RISE]) |-> irq)
		else $error("enabled lock rise flag gave no irq");

	chk_irq_bo_sync: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_BROWNOUT_SYNC_RDY] && state.enables[BIT_BROWNOUT_SYNC_RDY]) |-> irq)
		else $error("enabled brownout sync flag gave no irq");

	chk_irq_bo_det: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_BROWNOUT_DETECTED] && state.enables[BIT_BROWNOUT_DETECTED]) |-> irq)
		else $error("enabled brownout detect flag gave no irq");

	chk_irq_bo_ready: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_BROWNOUT_READY] && state.enables[BIT_BROWNOUT_READY]) |-> irq)
		else $error("enabled brownout ready flag gave no irq");

	chk_irq_ref_stop: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_FLL_REF_STOPPED] && state.enables[BIT_FLL_REF_STOPPED]) |-> irq)
		else $error("enabled reference stop flag gave no irq");

	chk_irq_coarse: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_FLL_COARSE_LOCK] && state.enables[BIT_FLL_COARSE_LOCK]) |-> irq)
		else $error("enabled coarse lock flag gave no irq");

	chk_irq_fine: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_FLL_FINE_LOCK] && state.enables[BIT_FLL_FINE_LOCK]) |-> irq)
		else $error("enabled fine lock flag gave no irq");

	chk_irq_oob: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_FLL_OUT_OF_BOUNDS] && state.enables[BIT_FLL_OUT_OF_BOUNDS]) |-> irq)
		else $error("enabled out of bounds flag gave no irq");

	chk_irq_fll_rdy: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_FLL_READY] && state.enables[BIT_FLL_READY]) |-> irq)
		else $error("enabled fll ready flag gave no irq");

	chk_irq_rc8m: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_RC8M_READY] && state.enables[BIT_RC8M_READY]) |-> irq)
		else $error("enabled 8 MHz ready flag gave no irq");

	chk_irq_rc32k: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_RC32K_READY] && state.enables[BIT_RC32K_READY]) |-> irq)
		else $error("enabled 32 kHz ready flag gave no irq");

	chk_irq_xtal32k: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_CRYSTAL32K_READY] && state.enables[BIT_CRYSTAL32K_READY]) |-> irq)
		else $error("enabled 32 kHz crystal flag gave no irq");

	chk_irq_xtal_bit: assert property (@(posedge clock) disable iff (reset)
		(state.flags[BIT_CRYSTAL_READY] && state.enables[BIT_CRYSTAL_READY]) |-> irq)
		else $error("enabled crystal flag gave no irq");

	// enables, held flags and the idle read port

	chk_enable_clear: assert property (@(posedge clock) disable iff (reset)
		(reg_write && reg_addr == OFF_ENABLE_CLR && reg_wdata[BIT_CRYSTAL_READY]) |=> !state.enables[BIT_CRYSTAL_READY])
		else $error("enable clear did not take");

	chk_flag_hold: assert property (@(posedge clock) disable iff (reset)
		(!(reg_write && reg_addr == OFF_FLAGS) && state.flags[BIT_FLL_COARSE_LOCK]) |=> state.flags[BIT_FLL_COARSE_LOCK])
		else $error("flag dropped without a clear");

	chk_enable_spare: assert property (@(posedge clock) disable iff (reset)
		(state.enables & ~EVENT_MASK) == READ_ZERO)
		else $error("spare enable bit holds a one");

	chk_rdata_idle: assert property (@(posedge clock) disable iff (reset)
		!reg_read |=> reg_rdata == READ_ZERO)
		else $error("read data not zero outside a read");

	cov_flag_irq:   cover property (@(posedge clock) disable iff (reset) $rose(irq));
	cov_clear_irq:  cover property (@(posedge clock) disable iff (reset) $fell(irq));
	cov_set_clear:  cover property (@(posedge clock) disable iff (reset)
		reg_write && reg_addr == OFF_FLAGS && (rise & reg_wdata) != READ_ZERO);
	cov_status_rd:  cover property (@(posedge clock) disable iff (reset)
		reg_read && reg_addr == OFF_STATUS ##1 reg_rdata != READ_ZERO);
endmodule

//--- scif_pkg.sv
// package for the clock and power event flag block: offsets, bit positions, reset values.
// assumes a single clock domain and a plain strobe register port.
package scif_pkg;
	// register byte offsets
	localparam logic [7:0]  OFF_ENABLE_CLR = 8'h00;  // enable-clear register
	localparam logic [7:0]  OFF_ENABLE_SET = 8'h04;  // irq_enable_set_reg
	localparam logic [7:0]  OFF_FLAGS      = 8'h08;  // clock_power_event_flags
	localparam logic [7:0]  OFF_STATUS     = 8'h0c;  // clock_power_live_status
	// bit positions
	localparam int BIT_PLL_LOCK_TIMEOUT  = 17;
	localparam int BIT_PLL_LOCK_FALL     = 16;
	localparam int BIT_PLL_LOCK_RISE     = 15;
	localparam int BIT_BROWNOUT_SYNC_RDY = 11;
	localparam int BIT_BROWNOUT_DETECTED = 10;
	localparam int BIT_BROWNOUT_READY    = 9;
	localparam int BIT_FLL_REF_STOPPED   = 8;
	localparam int BIT_FLL_COARSE_LOCK   = 7;
	localparam int BIT_FLL_FINE_LOCK     = 6;
	localparam int BIT_FLL_OUT_OF_BOUNDS = 5;
	localparam int BIT_FLL_READY         = 4;
	localparam int BIT_RC8M_READY        = 3;
	localparam int BIT_RC32K_READY       = 2;
	localparam int BIT_CRYSTAL32K_READY  = 1;
	localparam int BIT_CRYSTAL_READY     = 0;
	// implemented bits: 17..15 and 11..0
	localparam logic [31:0] EVENT_MASK  = 32'h0003_8fff;
	localparam logic [31:0] RESET_FLAGS = 32'h0000_0000;
	localparam logic [31:0] RESET_STAT  = 32'h0000_0000;
	localparam logic [31:0] RESET_EN    = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO   = 32'h0000_0000;
endpackage

//--- scif_status_model.sv
// status source model: the live levels of oscillators, loops and brown-out detector.
// assumes the bench names the wanted levels; each change lands just after a clock edge.
module scif_status_model
	import scif_pkg::*;
(
	input  wire logic        clock,
	input  wire logic [31:0] want,
	output logic      [31:0] levels
);
	// register the wanted levels so they move right after an edge, as a real source would
	// unassigned positions stay low: no source sits there
	always_ff @(posedge clock) begin
		levels <= want & EVENT_MASK;
	end
endmodule

//--- sysctrl_irq_flags_status_bench.sv
// bench for the clock and power event flags: register reads, flag edges, enables, irq.
// assumes scif_pkg, scif_event_flags and scif_status_model are compiled first.
module sysctrl_irq_flags_status_bench
	import scif_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;       // 125 MHz
	logic        reset = 1'b1;       // synchronous, active high
	logic [7:0]  reg_addr = 8'h00;   // register port
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] want = 32'h0000_0000; // levels asked of the source model
	logic [31:0] src;                  // levels the model drives
	logic        irq;
	int          n_fail = 0;
	int          n_compared = 0;

	// clock: toggles every half period
	always #4 clock = ~clock;

	scif_status_model model (.clock(clock), .want(want), .levels(src));

	scif_event_flags DUT (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.pll_lock_timeout(src[17]), .pll_lock_fall(src[16]), .pll_lock_rise(src[15]),
		.brownout_sync_ready(src[11]), .brownout_detected(src[10]), .brownout_ready(src[9]),
		.fll_ref_clock_stopped(src[8]), .fll_coarse_lock(src[7]), .fll_fine_lock(src[6]),
		.fll_out_of_bounds(src[5]), .fll_ready(src[4]), .rc8m_ready(src[3]), .rc32k_ready(src[2]),
		.crystal32k_ready(src[1]), .crystal_ready(src[0]), .irq(irq));

	// case equality, so an unknown never passes
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// one-cycle read strobe; data stand only in the following cycle, so look there
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic chk_irq(input logic e);
		#1 check({31'h0, irq}, {31'h0, e});
	endtask
	// model latency one edge, two sync flops, one flag edge: six cycles leaves margin
	task automatic set_src(input logic [31:0] w);
		@(posedge clock);
		want <= w;
		repeat (6) @(posedge clock);
	endtask

	// reset values, unmapped address reads zero
	task automatic t_reset;
		rdc(OFF_FLAGS, RESET_FLAGS);
		rdc(OFF_STATUS, RESET_STAT);
		rdc(8'h10, READ_ZERO);
		chk_irq(1'b0);
	endtask
	// every source rises; flags follow but stay quiet with no enables
	task automatic t_rise_all;
		set_src(32'hFFFF_FFFF);
		rdc(OFF_STATUS, EVENT_MASK);
		rdc(OFF_FLAGS, EVENT_MASK);
		rdc(OFF_FLAGS, EVENT_MASK);
		chk_irq(1'b0);
		wr(OFF_STATUS, 32'h0000_0000);
		rdc(OFF_STATUS, EVENT_MASK);
		wr(OFF_FLAGS, 32'h0000_0000);
		rdc(OFF_FLAGS, EVENT_MASK);
	endtask
	// enable and disable one flag, then clear flags while levels stay high
	task automatic t_enable;
		wr(OFF_ENABLE_SET, 32'h0002_0000);
		chk_irq(1'b1);
		wr(OFF_ENABLE_CLR, 32'h0002_0000);
		chk_irq(1'b0);
		wr(OFF_FLAGS, 32'h0000_0001);
		rdc(OFF_FLAGS, EVENT_MASK & 32'hFFFF_FFFE);
		wr(OFF_FLAGS, 32'hFFFF_FFFF);
		rdc(OFF_FLAGS, READ_ZERO);
	endtask
	// crystal ready falls and rises again with its enable on
	task automatic t_crystal;
		set_src(32'hFFFF_FFFE);
		wr(OFF_ENABLE_SET, 32'h0000_0001);
		chk_irq(1'b0);
		set_src(32'hFFFF_FFFF);
		rdc(OFF_FLAGS, 32'h0000_0001);
		chk_irq(1'b1);
		wr(OFF_ENABLE_SET, 32'h0000_0000);
		chk_irq(1'b1);
		wr(OFF_ENABLE_CLR, 32'h0000_0001);
		chk_irq(1'b0);
	endtask

	// crystal rises again in the very cycle software clears its flag: the set must win
	task automatic t_race;
		set_src(32'hFFFF_FFFE);
		wr(OFF_FLAGS, 32'h0000_0001);
		rdc(OFF_FLAGS, READ_ZERO);
		@(posedge clock);
		want <= 32'hFFFF_FFFF;
		// model edge, two sync edges; the clear below is sampled on the flag-setting edge
		repeat (2) @(posedge clock);
		wr(OFF_FLAGS, 32'h0000_0001);
		rdc(OFF_FLAGS, 32'h0000_0001);
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence: six reset cycles, then the scenarios
	initial begin
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		t_reset;
		t_rise_all;
		t_enable;
		t_crystal;
		t_race;
		report_and_stop;
	end
	// watchdog: the tests need some 85 cycles
	initial begin
		#20000;
		n_fail++;
		report_and_stop;
	end
endmodule
